// ---- accel_regs_pkg.sv ----
package accel_regs_pkg;
    // register offsets
    localparam logic [7:0] OFS_MOTION_SRC = 8'h16;
    localparam logic [7:0] OFS_STATUS = 8'h17;
    localparam logic [7:0] OFS_LATCH_REL = 8'h19;
    localparam logic [7:0] OFS_MAIN_CTL = 8'h1a;
    localparam logic [7:0] OFS_RESET_CTL = 8'h1b;
    localparam logic [7:0] OFS_RATE_CTL = 8'h1c;
    localparam logic [7:0] OFS_MOTION_CTL = 8'h1d;
    localparam logic [7:0] OFS_SELFCHECK = 8'h10;
    // reset values, selfcheck responses and release read value
    localparam logic [7:0] RST_MAIN_CTL = 8'h00;
    localparam logic [7:0] RST_RESET_CTL = 8'h3f;
    localparam logic [7:0] RST_RATE_CTL = 8'h98;
    localparam logic [7:0] RST_MOTION_CTL = 8'h40;
    localparam logic [7:0] SELFCHECK_IDLE = 8'h55;
    localparam logic [7:0] SELFCHECK_ACTIVE = 8'haa;
    localparam logic [7:0] LATCH_REL_DUMMY = 8'h00;
    // field positions
    localparam int BIT_WAKE_FLAG = 7;
    localparam int BIT_SLEEP_FLAG = 6;
    localparam int BIT_PENDING = 4;
    localparam int BIT_WAKE_STATE = 0;
    localparam int BIT_OPERATE = 7;
    localparam int BIT_PERF = 6;
    localparam int BIT_NEW_SAMPLE = 5;
    localparam int BIT_RANGE_HI = 4;
    localparam int BIT_RANGE_LO = 3;
    localparam int BIT_TAP_EN = 2;
    localparam int BIT_STEP_EN = 1;
    localparam int BIT_ORIENT_EN = 0;
    localparam int BIT_REBOOT = 7;
    localparam int BIT_SELFCHECK = 6;
    localparam int BIT_DEBOUNCE = 7;
    localparam int BIT_THRESH_KIND = 6;
    localparam int BIT_WAKE_EN = 5;
    localparam int BIT_SLEEP_EN = 4;
    localparam int BIT_HIGHPASS_EN = 3;
    // reboot timing
    localparam int REBOOT_TIME_US = 50;
    localparam int CLK_MHZ = 20;
    localparam int REBOOT_CYCLES = REBOOT_TIME_US * CLK_MHZ;

    // range choice decoded from the two select bits
    typedef enum logic [1:0] {
        RANGE_2G = 2'b00,
        RANGE_4G = 2'b01,
        RANGE_8G = 2'b10
    } range_t;

    // motion event bundle from the engines
    typedef struct packed {
        logic wake;
        logic sleep;
        logic [5:0] axis;
    } motion_evt_t;

    // register access strobe bundle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// ---- accel_irq_status_control_regs.sv ----
`timescale 1ns/10ps
module accel_irq_status_control_regs #(
    parameter int REBOOT_CYCLES = accel_regs_pkg::REBOOT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire accel_regs_pkg::reg_req_t req,
    input wire accel_regs_pkg::motion_evt_t motion_evt,
    input wire logic other_src_pending,
    input wire logic new_sample,
    input wire logic buffer_full_flag,
    input wire logic buffer_watermark_flag,
    input wire logic step_watermark_flag,
    input wire logic manual_wake,
    input wire logic manual_sleep,
    output logic [7:0] rdata,
    output logic wr_nack,
    output logic source_clear,
    output logic irq_latched,
    output logic operate_select,
    output logic perf_mode_select,
    output logic new_sample_irq_enable,
    output accel_regs_pkg::range_t range_sel,
    output logic tap_engine_enable,
    output logic step_engine_enable,
    output logic orientation_engine_enable,
    output logic [5:0] orient_masks,
    output logic [1:0] orientation_rate,
    output logic [2:0] tap_rate,
    output logic [2:0] wake_rate,
    output logic debounce_decrement,
    output logic threshold_kind,
    output logic wake_engine_enable,
    output logic sleep_engine_enable,
    output logic highpass_output_enable,
    output logic [2:0] sleep_rate,
    output logic reboot_active
);

    ////////////////////////////////////////////////////////////////////////////
    // access decode
    logic rd_rel;
    logic rd_selfcheck;
    logic wr_main;
    logic wr_reset_ctl;
    logic wr_rate;
    logic wr_motion;
    logic [7:0] main_ctl_q;
    logic [7:0] reset_ctl_q;
    logic [7:0] rate_ctl_q;
    logic [7:0] motion_ctl_q;
    logic [7:0] selfcheck_q;
    logic wake_flag_q;
    logic sleep_flag_q;
    logic [5:0] axis_q;
    logic data_ready_q;
    logic wake_state_q;
    logic pending;
    logic [15:0] reboot_cnt_q;
    logic reboot_done;

    // read-only offsets take no write and no side effect
    function automatic logic is_wr(input accel_regs_pkg::reg_req_t r, input logic [7:0] a);
        return r.wr && !r.rd && (r.addr == a);
    endfunction

    assign rd_rel = clk_en && req.rd && (req.addr == accel_regs_pkg::OFS_LATCH_REL);
    assign rd_selfcheck = clk_en && req.rd && (req.addr == accel_regs_pkg::OFS_SELFCHECK);
    assign wr_main = clk_en && is_wr(req, accel_regs_pkg::OFS_MAIN_CTL) && !reboot_active;
    assign wr_reset_ctl = clk_en && is_wr(req, accel_regs_pkg::OFS_RESET_CTL) && !reboot_active;
    assign wr_rate = clk_en && is_wr(req, accel_regs_pkg::OFS_RATE_CTL) && !reboot_active;
    assign wr_motion = clk_en && is_wr(req, accel_regs_pkg::OFS_MOTION_CTL) && !reboot_active;
    // last counted cycle of the reboot, while reboot_active still stands
    assign reboot_done = clk_en && (reboot_cnt_q == 16'h0001);

    ////////////////////////////////////////////////////////////////////////////
    // control registers, reloaded to defaults by soft reboot
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            main_ctl_q <= accel_regs_pkg::RST_MAIN_CTL;
        end else if (reboot_done) begin
            main_ctl_q <= accel_regs_pkg::RST_MAIN_CTL;
        end else if (wr_main) begin
            main_ctl_q <= req.wdata;
        end
    end

    // rate control: orientation, tap and wake rate codes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rate_ctl_q <= accel_regs_pkg::RST_RATE_CTL;
        end else if (reboot_done) begin
            rate_ctl_q <= accel_regs_pkg::RST_RATE_CTL;
        end else if (wr_rate) begin
            rate_ctl_q <= req.wdata;
        end
    end

    // motion engine control
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            motion_ctl_q <= accel_regs_pkg::RST_MOTION_CTL;
        end else if (reboot_done) begin
            motion_ctl_q <= accel_regs_pkg::RST_MOTION_CTL;
        end else if (wr_motion) begin
            motion_ctl_q <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reboot, selfcheck and orientation mask register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reset_ctl_q <= accel_regs_pkg::RST_RESET_CTL;
        end else if (clk_en) begin
            if (reboot_done) begin
                reset_ctl_q <= accel_regs_pkg::RST_RESET_CTL;
            end else if (wr_reset_ctl) begin
                reset_ctl_q <= req.wdata;
            end else if (rd_selfcheck && selfcheck_q == accel_regs_pkg::SELFCHECK_ACTIVE) begin
                reset_ctl_q[accel_regs_pkg::BIT_SELFCHECK] <= 1'b0;
            end
        end
    end

    // reboot counter runs while the reboot bit stands
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reboot_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            if (wr_reset_ctl && req.wdata[accel_regs_pkg::BIT_REBOOT]) begin
                reboot_cnt_q <= 16'(REBOOT_CYCLES - 1);
            end else if (reboot_cnt_q != 16'h0000) begin
                reboot_cnt_q <= reboot_cnt_q - 16'h0001;
            end
        end
    end

    // no acknowledge for the byte that starts the reboot
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_nack <= 1'b0;
        end else if (clk_en) begin
            wr_nack <= wr_reset_ctl && req.wdata[accel_regs_pkg::BIT_REBOOT];
        end
    end

    // selfcheck response register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            selfcheck_q <= accel_regs_pkg::SELFCHECK_IDLE;
        end else if (clk_en) begin
            if (wr_reset_ctl && req.wdata[accel_regs_pkg::BIT_SELFCHECK]) begin
                selfcheck_q <= accel_regs_pkg::SELFCHECK_ACTIVE;
            end else if (rd_selfcheck) begin
                selfcheck_q <= accel_regs_pkg::SELFCHECK_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched motion source flags, set beats release clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_flag_q <= 1'b0;
            sleep_flag_q <= 1'b0;
            axis_q <= 6'h00;
        end else if (clk_en) begin
            if (motion_evt.wake && motion_ctl_q[accel_regs_pkg::BIT_WAKE_EN]) begin
                wake_flag_q <= 1'b1;
                axis_q <= motion_evt.axis;
            end else if (rd_rel) begin
                wake_flag_q <= 1'b0;
                axis_q <= 6'h00;
            end
            if (motion_evt.sleep && motion_ctl_q[accel_regs_pkg::BIT_SLEEP_EN]) begin
                sleep_flag_q <= 1'b1;
            end else if (rd_rel) begin
                sleep_flag_q <= 1'b0;
            end
        end
    end

    // data ready source, gated by new-sample enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_ready_q <= 1'b0;
        end else if (clk_en) begin
            if (new_sample && main_ctl_q[accel_regs_pkg::BIT_NEW_SAMPLE]) begin
                data_ready_q <= 1'b1;
            end else if (rd_rel) begin
                data_ready_q <= 1'b0;
            end
        end
    end

    // wake or sleep state, awake after power-up
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_state_q <= 1'b1;
        end else if (clk_en) begin
            if (manual_wake || (motion_evt.wake && motion_ctl_q[accel_regs_pkg::BIT_WAKE_EN])) begin
                wake_state_q <= 1'b1;
            end else if (manual_sleep ||
                         (motion_evt.sleep && motion_ctl_q[accel_regs_pkg::BIT_SLEEP_EN])) begin
                wake_state_q <= 1'b0;
            end
        end
    end

    // summary: buffer and step watermarks are not released here
    assign pending = wake_flag_q || sleep_flag_q || data_ready_q || other_src_pending ||
                     buffer_full_flag || buffer_watermark_flag || step_watermark_flag;

    ////////////////////////////////////////////////////////////////////////////
    // read data, release strobe and latched pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
            source_clear <= 1'b0;
            irq_latched <= 1'b0;
        end else if (clk_en) begin
            source_clear <= rd_rel;
            irq_latched <= pending && !rd_rel;
            if (req.rd) begin
                case (req.addr)
                    accel_regs_pkg::OFS_MOTION_SRC: rdata <= {wake_flag_q, sleep_flag_q, axis_q};
                    accel_regs_pkg::OFS_STATUS: rdata <= {3'h0, pending, 3'h0, wake_state_q};
                    accel_regs_pkg::OFS_LATCH_REL: rdata <= accel_regs_pkg::LATCH_REL_DUMMY;
                    accel_regs_pkg::OFS_MAIN_CTL: rdata <= main_ctl_q;
                    accel_regs_pkg::OFS_RESET_CTL: rdata <= reset_ctl_q;
                    accel_regs_pkg::OFS_RATE_CTL: rdata <= rate_ctl_q;
                    accel_regs_pkg::OFS_MOTION_CTL: rdata <= motion_ctl_q;
                    accel_regs_pkg::OFS_SELFCHECK: rdata <= selfcheck_q;
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered control outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            operate_select <= 1'b0;
            perf_mode_select <= 1'b0;
            new_sample_irq_enable <= 1'b0;
            range_sel <= accel_regs_pkg::RANGE_2G;
            tap_engine_enable <= 1'b0;
            step_engine_enable <= 1'b0;
            orientation_engine_enable <= 1'b0;
            orient_masks <= 6'h3f;
            orientation_rate <= 2'h2;
            tap_rate <= 3'h3;
            wake_rate <= 3'h0;
            debounce_decrement <= 1'b0;
            threshold_kind <= 1'b1;
            wake_engine_enable <= 1'b0;
            sleep_engine_enable <= 1'b0;
            highpass_output_enable <= 1'b0;
            sleep_rate <= 3'h0;
            reboot_active <= 1'b0;
        end else if (clk_en) begin
            operate_select <= main_ctl_q[accel_regs_pkg::BIT_OPERATE];
            perf_mode_select <= main_ctl_q[accel_regs_pkg::BIT_PERF];
            new_sample_irq_enable <= main_ctl_q[accel_regs_pkg::BIT_NEW_SAMPLE];
            if (main_ctl_q[accel_regs_pkg::BIT_RANGE_HI]) begin
                range_sel <= accel_regs_pkg::RANGE_8G;
            end else if (main_ctl_q[accel_regs_pkg::BIT_RANGE_LO]) begin
                range_sel <= accel_regs_pkg::RANGE_4G;
            end else begin
                range_sel <= accel_regs_pkg::RANGE_2G;
            end
            tap_engine_enable <= main_ctl_q[accel_regs_pkg::BIT_TAP_EN];
            step_engine_enable <= main_ctl_q[accel_regs_pkg::BIT_STEP_EN];
            orientation_engine_enable <= main_ctl_q[accel_regs_pkg::BIT_ORIENT_EN];
            orient_masks <= reset_ctl_q[5:0];
            orientation_rate <= rate_ctl_q[7:6];
            tap_rate <= rate_ctl_q[5:3];
            wake_rate <= rate_ctl_q[2:0];
            debounce_decrement <= motion_ctl_q[accel_regs_pkg::BIT_DEBOUNCE];
            threshold_kind <= motion_ctl_q[accel_regs_pkg::BIT_THRESH_KIND];
            wake_engine_enable <= motion_ctl_q[accel_regs_pkg::BIT_WAKE_EN];
            sleep_engine_enable <= motion_ctl_q[accel_regs_pkg::BIT_SLEEP_EN];
            highpass_output_enable <= motion_ctl_q[accel_regs_pkg::BIT_HIGHPASS_EN];
            sleep_rate <= motion_ctl_q[2:0];
            reboot_active <= (wr_reset_ctl && req.wdata[accel_regs_pkg::BIT_REBOOT]) ||
                             (reboot_cnt_q > 16'h0001);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_release;
        clk_en && rd_rel;
    endsequence

    a_wake_set: assert property (@(posedge clk) disable iff (reset)
        clk_en && motion_evt.wake && motion_ctl_q[5] |=> wake_flag_q)
        else $error("wake flag not set");
    a_wake_clear: assert property (@(posedge clk) disable iff (reset)
        s_release and !motion_evt.wake |=> !wake_flag_q)
        else $error("wake flag not cleared by release");
    a_sleep_clear: assert property (@(posedge clk) disable iff (reset)
        s_release and !motion_evt.sleep |=> !sleep_flag_q)
        else $error("sleep flag not cleared by release");
    a_release_zero: assert property (@(posedge clk) disable iff (reset)
        s_release |=> rdata == 8'h00 && source_clear)
        else $error("release read not zero");
    a_pending_held: assert property (@(posedge clk) disable iff (reset)
        s_release and step_watermark_flag |=> pending)
        else $error("pending dropped with watermark set");
    a_selfcheck_load: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_reset_ctl && req.wdata[6] |=> selfcheck_q == 8'haa)
        else $error("selfcheck not loaded");
    a_reboot_hold: assert property (@(posedge clk) disable iff (reset)
        clk_en && wr_reset_ctl && req.wdata[7] |=> reboot_active && wr_nack)
        else $error("reboot not started");
    a_ro_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.wr && !req.rd && req.addr == 8'h16 && !motion_evt.wake
        |=> $stable(wake_flag_q))
        else $error("read-only write changed flag");
    a_range_code: assert property (@(posedge clk) disable iff (reset)
        clk_en && main_ctl_q[4] |=> range_sel == accel_regs_pkg::RANGE_8G)
        else $error("range not 8g");
    a_sleep_set: assert property (@(posedge clk) disable iff (reset)
        clk_en && motion_evt.sleep && motion_ctl_q[4] |=> sleep_flag_q)
        else $error("sleep flag not set");
    a_reboot_reload: assert property (@(posedge clk) disable iff (reset)
        reboot_done |=> reset_ctl_q == accel_regs_pkg::RST_RESET_CTL && !reboot_active)
        else $error("reboot did not reload defaults");
    a_selfcheck_restore: assert property (@(posedge clk) disable iff (reset)
        rd_selfcheck |=> selfcheck_q == accel_regs_pkg::SELFCHECK_IDLE)
        else $error("selfcheck not restored");
    a_ready_gated: assert property (@(posedge clk) disable iff (reset)
        clk_en && new_sample && !main_ctl_q[5] && !data_ready_q |=> !data_ready_q)
        else $error("data ready set while disabled");
    a_nack_pulse: assert property (@(posedge clk) disable iff (reset)
        wr_nack ##1 clk_en |=> !wr_nack)
        else $error("nack longer than one cycle");
    a_release_pin: assert property (@(posedge clk) disable iff (reset)
        s_release |=> !irq_latched)
        else $error("latched pin not released");
    a_manual_wake: assert property (@(posedge clk) disable iff (reset)
        clk_en && manual_wake |=> wake_state_q)
        else $error("manual wake not taken");
endmodule

// ---- host_reg_model.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// host side of the register access port, one byte per access
module host_reg_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic wr_nack,
    output accel_regs_pkg::reg_req_t req
);
    ////////////////////////////////////////////////////////////////////////////
    // nothing requested at time zero
    initial begin
        req = '0;
    end

    // launch after an edge, hold through the taking edge, then release
    task automatic access(input logic is_rd, input logic [7:0] addr,
                          input logic [7:0] wdata, output logic [7:0] rd_val,
                          output logic nack);
        @(posedge clk);
        req <= '{rd: is_rd, wr: !is_rd, addr: addr, wdata: wdata};
        @(posedge clk);
        // released fields show the inverse so a stale sample never matches
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        #1;
        rd_val = rdata;
        // a missing acknowledge on the reboot byte is taken as confirmation
        nack = wr_nack;
    endtask
endmodule

// ---- accel_irq_status_control_regs_tb.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module accel_irq_status_control_regs_tb;
    typedef struct {
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
        int view;
        logic [7:0] vexp;
    } row_t;
    logic clk;
    logic reset;
    logic clk_en;
    accel_regs_pkg::reg_req_t req;
    accel_regs_pkg::motion_evt_t motion_evt;
    logic other_src_pending;
    logic [2:0] pls;
    logic [2:0] bflags;
    logic [7:0] rdata;
    logic wr_nack;
    logic [7:0] q;
    logic nk;
    int n_mismatch;
    int total_checks;
    row_t rows[22];

    ////////////////////////////////////////////////////////////////////////////
    accel_irq_status_control_regs #(.REBOOT_CYCLES(4)) dut (
        .clk(clk), .reset(reset), .clk_en(clk_en), .req(req), .motion_evt(motion_evt),
        .other_src_pending(other_src_pending), .new_sample(pls[0]),
        .buffer_full_flag(bflags[0]), .buffer_watermark_flag(bflags[1]),
        .step_watermark_flag(bflags[2]), .manual_wake(pls[1]), .manual_sleep(pls[2]),
        .rdata(rdata), .wr_nack(wr_nack), .source_clear(), .irq_latched(),
        .operate_select(), .perf_mode_select(), .new_sample_irq_enable(), .range_sel(),
        .tap_engine_enable(), .step_engine_enable(), .orientation_engine_enable(),
        .orient_masks(), .orientation_rate(), .tap_rate(), .wake_rate(),
        .debounce_decrement(), .threshold_kind(), .wake_engine_enable(),
        .sleep_engine_enable(), .highpass_output_enable(), .sleep_rate(),
        .reboot_active()
    );

    host_reg_model host (.clk(clk), .rdata(rdata), .wr_nack(wr_nack), .req(req));

    ////////////////////////////////////////////////////////////////////////////
    // clock at 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // control outputs gathered per register
    function automatic logic [7:0] ctl_view(int k);
        case (k)
            1: return {dut.operate_select, dut.perf_mode_select, dut.new_sample_irq_enable,
                       dut.range_sel, dut.tap_engine_enable, dut.step_engine_enable,
                       dut.orientation_engine_enable};
            2: return {dut.orientation_rate, dut.tap_rate, dut.wake_rate};
            3: return {dut.debounce_decrement, dut.threshold_kind, dut.wake_engine_enable,
                       dut.sleep_engine_enable, dut.highpass_output_enable, dut.sleep_rate};
            default: return {2'h0, dut.orient_masks};
        endcase
    endfunction

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        host.access(1'b1, a, 8'h00, q, nk);
        check8(q & m, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b0, a, d, q, nk);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse_evt(input accel_regs_pkg::motion_evt_t e);
        @(posedge clk);
        motion_evt <= e;
        @(posedge clk);
        motion_evt <= '{wake: 1'b0, sleep: 1'b0, axis: e.axis};
    endtask

    task automatic pulse(input logic [2:0] p);
        @(posedge clk);
        pls <= p;
        @(posedge clk);
        pls <= 3'h0;
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #(50 * 3000);
        n_mismatch++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: table first, then hand-written cases
    initial begin
        rows = '{
            '{1'b1, 8'h1a, 8'h00, 0, 8'h00},
            '{1'b1, 8'h1b, 8'h3f, 0, 8'h00},
            '{1'b1, 8'h1c, 8'h98, 0, 8'h00},
            '{1'b1, 8'h1d, 8'h40, 0, 8'h00},
            '{1'b1, 8'h10, 8'h55, 0, 8'h00},
            '{1'b1, 8'h17, 8'h01, 0, 8'h00},
            '{1'b1, 8'h16, 8'h00, 0, 8'h00},
            '{1'b0, 8'h1a, 8'h1f, 1, 8'h17},
            '{1'b1, 8'h1a, 8'h1f, 0, 8'h00},
            '{1'b0, 8'h1a, 8'h0b, 1, 8'h0b},
            '{1'b0, 8'h1a, 8'h03, 1, 8'h03},
            '{1'b0, 8'h1a, 8'h60, 1, 8'h60},
            '{1'b0, 8'h1c, 8'h47, 2, 8'h47},
            '{1'b0, 8'h1d, 8'hb9, 3, 8'hb9},
            '{1'b0, 8'h1b, 8'h15, 4, 8'h15},
            '{1'b1, 8'h1b, 8'h15, 0, 8'h00},
            '{1'b0, 8'h16, 8'hff, 0, 8'h00},
            '{1'b0, 8'h17, 8'hff, 0, 8'h00},
            '{1'b0, 8'h30, 8'hff, 0, 8'h00},
            '{1'b1, 8'h16, 8'h00, 0, 8'h00},
            '{1'b1, 8'h17, 8'h01, 0, 8'h00},
            '{1'b0, 8'h1a, 8'h80, 1, 8'h80}
        };
        reset = 1'b1;
        clk_en = 1'b1;
        other_src_pending = 1'b0;
        pls = 3'h0;
        bflags = 3'h0;
        motion_evt = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // controls change on each control-register write, operate bit set or clear
        foreach (rows[i]) begin
            if (rows[i].rd === 1'b1) begin
                rd_chk(rows[i].addr, rows[i].data, 8'hff);
            end else begin
                wr(rows[i].addr, rows[i].data);
                check1(nk, 1'b0);
                if (rows[i].view != 0) begin
                    wait_cyc(2);
                    check8(ctl_view(rows[i].view), rows[i].vexp);
                end
            end
        end
        // wake event with its axis cause, then release
        pulse_evt('{wake: 1'b1, sleep: 1'b0, axis: 6'b100001});
        rd_chk(8'h16, 8'ha1, 8'hff);
        rd_chk(8'h17, 8'h10, 8'h10);
        check1(dut.irq_latched, 1'b1);
        rd_chk(8'h19, 8'h00, 8'hff);
        check1(dut.source_clear, 1'b1);
        rd_chk(8'h16, 8'h00, 8'hff);
        rd_chk(8'h17, 8'h00, 8'h10);
        check1(dut.irq_latched, 1'b0);
        // sleep flag survives a write to the release register
        pulse_evt('{wake: 1'b0, sleep: 1'b1, axis: 6'h00});
        wr(8'h19, 8'hff);
        rd_chk(8'h16, 8'h40, 8'hff);
        rd_chk(8'h19, 8'h00, 8'hff);
        rd_chk(8'h16, 8'h00, 8'hff);
        // each buffer or step flag holds pending across a release
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            bflags <= 3'h1 << i;
            rd_chk(8'h19, 8'h00, 8'hff);
            rd_chk(8'h17, 8'h10, 8'h10);
            @(posedge clk);
            bflags <= 3'h0;
            rd_chk(8'h17, 8'h00, 8'h10);
        end
        // data-ready interrupt only while enabled
        wr(8'h1a, 8'h00);
        wr(8'h1a, 8'h20);
        pulse(3'b001);
        rd_chk(8'h17, 8'h10, 8'h10);
        rd_chk(8'h19, 8'h00, 8'hff);
        wr(8'h1a, 8'h00);
        pulse(3'b001);
        rd_chk(8'h17, 8'h00, 8'h10);
        // other latched sources feed pending
        @(posedge clk);
        other_src_pending <= 1'b1;
        rd_chk(8'h17, 8'h10, 8'h10);
        @(posedge clk);
        other_src_pending <= 1'b0;
        // manual wake, sleep, then wake again in the state bit
        pulse(3'b010);
        rd_chk(8'h17, 8'h01, 8'h01);
        pulse(3'b100);
        rd_chk(8'h17, 8'h00, 8'h01);
        pulse(3'b010);
        rd_chk(8'h17, 8'h01, 8'h01);
        // selfcheck response flips once
        wr(8'h1b, 8'h7f);
        rd_chk(8'h10, 8'haa, 8'hff);
        rd_chk(8'h10, 8'h55, 8'hff);
        rd_chk(8'h1b, 8'h3f, 8'hff);
        // soft reboot: no acknowledge, bit reads set, defaults after
        wr(8'h1b, 8'h80);
        check1(nk, 1'b1);
        check1(dut.reboot_active, 1'b1);
        rd_chk(8'h1b, 8'h80, 8'h80);
        for (int i = 0; i < 20 && dut.reboot_active === 1'b1; i++) begin
            wait_cyc(1);
        end
        check1(dut.reboot_active, 1'b0);
        rd_chk(8'h1c, 8'h98, 8'hff);
        rd_chk(8'h1d, 8'h40, 8'hff);
        rd_chk(8'h1b, 8'h3f, 8'hff);
        // a write while the clock enable is low is not taken
        @(posedge clk);
        clk_en <= 1'b0;
        wr(8'h1d, 8'h00);
        @(posedge clk);
        clk_en <= 1'b1;
        rd_chk(8'h1d, 8'h40, 8'hff);
        // reset in mid-run restores defaults
        wr(8'h1a, 8'h55);
        rd_chk(8'h1a, 8'h55, 8'hff);
        pulse(3'b100);
        rd_chk(8'h17, 8'h00, 8'h01);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk(8'h1a, 8'h00, 8'hff);
        rd_chk(8'h17, 8'h01, 8'h01);
        summarize();
    end
endmodule
